// ---- shared/dac_ctrl_pkg.sv ----
/*
 * Shared constants for the eight-channel converter control logic:
 * frame layout, command codes, strap decode tables and reset values.
 * Assumes one consumer that reads every name as dac_ctrl_pkg::name.
 */
package dac_ctrl_pkg;

    // Channel count and register widths
    localparam int unsigned CH_N    = 8;
    localparam int unsigned CODE_W  = 16;
    localparam int unsigned SPAN_W  = 3;
    localparam int unsigned FRAME_W = 32;
    localparam int unsigned CFG_W   = 4;
    localparam int unsigned MUX_W   = 5;

    // Field positions inside the last 24 bits of a frame
    localparam int unsigned CMD_LSB  = 20;
    localparam int unsigned ADDR_LSB = 16;
    localparam int unsigned DATA_MSB = 15;
    localparam int unsigned TG_BIT   = 0;

    // Command codes
    localparam logic [3:0] CMD_WR_N       = 4'h0;
    localparam logic [3:0] CMD_WR_ALL     = 4'h8;
    localparam logic [3:0] CMD_SPAN_N     = 4'h6;
    localparam logic [3:0] CMD_SPAN_ALL   = 4'hE;
    localparam logic [3:0] CMD_UPD_N      = 4'h1;
    localparam logic [3:0] CMD_UPD_ALL    = 4'h9;
    localparam logic [3:0] CMD_WR_UPD_N   = 4'h3;
    localparam logic [3:0] CMD_WR_N_UPD_A = 4'h2;
    localparam logic [3:0] CMD_WR_UPD_ALL = 4'hA;
    localparam logic [3:0] CMD_PD_N       = 4'h4;
    localparam logic [3:0] CMD_PD_CHIP    = 4'h5;
    localparam logic [3:0] CMD_MUX        = 4'hB;
    localparam logic [3:0] CMD_TSEL       = 4'hC;
    localparam logic [3:0] CMD_GTOGGLE    = 4'hD;
    localparam logic [3:0] CMD_CONFIG     = 4'h7;
    localparam logic [3:0] CMD_NOP        = 4'hF;

    // Reset codes and per-strap tables (span packed 3 bits per strap)
    localparam logic [CODE_W-1:0] MID_CODE  = 16'h8000;
    localparam logic [CODE_W-1:0] ZERO_CODE = 16'h0000;
    localparam logic [23:0] STRAP_SPAN_TBL  = 24'h001313;
    localparam logic [7:0]  STRAP_MID_TBL   = 8'h57;
    localparam logic [SPAN_W-1:0] RST_SPAN  = 3'h0;
    localparam logic [7:0]  ALL_CH          = 8'hFF;

    // Power-on span selected by the straps
    function automatic logic [SPAN_W-1:0] strap_span(
        input logic [2:0] s);
        strap_span = STRAP_SPAN_TBL[3*s +: 3];
    endfunction

    // Power-on code selected by the straps
    function automatic logic [CODE_W-1:0] strap_code(
        input logic [2:0] s);
        strap_code = STRAP_MID_TBL[s] ? MID_CODE : ZERO_CODE;
    endfunction

    // Address 0..7 to a one-hot channel mask; others select nothing
    function automatic logic [7:0] chan_mask(input logic [3:0] a);
        chan_mask = 8'h00;
        if (a < 4'h8) begin
            chan_mask[a[2:0]] = 1'b1;
        end
    endfunction

endpackage

// ---- src/level_sync.sv ----
/*
 * Two-flop synchroniser for a bundle of independent levels.
 * Assumes each bit changes slowly against i_clk; no word coherence.
 */
`timescale 1ns/1ps
`default_nettype none

module level_sync #(
    parameter int unsigned W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock, reset, enable
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_ce,
    // Levels
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);

    logic [W-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            meta   <= RST_VAL;
            o_sync <= RST_VAL;
        end else if (i_ce) begin
            meta   <= i_async;
            o_sync <= meta;
        end
    end

endmodule

`default_nettype wire

// ---- src/link_shifter.sv ----
/*
 * Link-side 32-bit shift register clocked by the serial clock.
 * Assumes the host holds the serial clock idle while the strobe is
 * high, so the word is stable for the system-clock side to read.
 */
`timescale 1ns/1ps
`default_nettype none

module link_shifter (
    // Link clock and framing
    input  wire logic        i_sck,
    input  wire logic        i_strobe_n,
    // Serial data
    input  wire logic        i_sdi,
    output logic             o_sdo,
    // Captured frame
    output logic [31:0]      o_word
);

    // Shift on rising edges only inside a frame
    always_ff @(posedge i_sck) begin
        if (!i_strobe_n) begin
            o_word <= {o_word[30:0], i_sdi};
        end
    end

    // Tail bit leaves on the falling edge after its 32nd rising edge
    always_ff @(negedge i_sck) begin
        o_sdo <= o_word[31];
    end

endmodule

`default_nettype wire

// ---- src/dac_serial_ctrl.sv ----
/*
 * Command interpreter of an eight-channel converter: decodes serial
 * frames, holds double-buffered code and span registers, power,
 * toggle and mux state, and serves the update, toggle, clear pins.
 * Assumes pins are asynchronous to i_clk and are synchronised here;
 * the serial clock is a second domain handled in link_shifter.
 */
// Behaviour
// - Strobe low shifts bits; strobe rise ends shifting and executes command.
// - Input bits are sampled on the rising serial clock edge.
// - Frames of 24 or 32 bits are both accepted.
// - Serial output is the 32-bit register tail, shifted out on falling edge.
// - Serial output is high impedance while the strobe is high.
// - Update pin falling with strobe high updates every channel at once.
// - Update pin falling with strobe low defers the update to strobe rise.
// - Update pin low powers channels up and blocks software power-down.
// - Toggle pin fall loads register A, rise loads register B.
// - Toggles act only on channels whose toggle select bit is 1.
// - Clear low forces strap code and span, zeroes control registers.
// - Three straps choose power-on span and code for all channels.
// - Overtemperature pulls the flag low until next strobe rise.
// - Commands 0000, 1000, 0110, 1110 write code or span, one or all.
// - Commands 0011, 0010, 1010 write code and update, powering up.
// - Commands 0001 and 1001 update one or all channels, powering up.
// - Command 0100 powers one channel down, 0101 the whole chip.
// - Commands 1011 mux, 1100 toggle select, 1101 toggle, 0111 config.
// - Address 0000..0111 selects channel 0..7.
// - Frame is command, address, then 16-bit data, MSB first.
// - A 12-bit code sits left-aligned, the four low bits ignored; the code here keeps all 16 data bits.
// - Writes load input registers; updates copy them to converters.
`timescale 1ns/1ps
`default_nettype none

module dac_serial_ctrl (
    // System clock, reset, enable
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_ce,
    // Serial link
    input  wire logic         i_sck,
    input  wire logic         i_sdi,
    input  wire logic         i_select_load_strobe_n,
    output logic              o_sdo,
    output logic              o_sdo_oe_n,
    // Control pins
    input  wire logic         i_async_update_n,
    input  wire logic         i_toggle_pin,
    input  wire logic         i_async_clear_n,
    input  wire logic [2:0]   i_span_strap_pins,
    // Overtemperature comparator and open-drain flag
    input  wire logic         i_overtemp,
    output logic              o_overtemp_flag_n,
    output logic              o_overtemp_flag_oe_n,
    // Converter and analog controls
    output logic [127:0]      o_dac_code,
    output logic [23:0]       o_dac_span,
    output logic [7:0]        o_dac_power,
    output logic              o_ref_en,
    output logic [4:0]        o_monitor_mux_sel,
    output logic [3:0]        o_config
);

    localparam int unsigned CW = dac_ctrl_pkg::CODE_W;
    localparam int unsigned SW = dac_ctrl_pkg::SPAN_W;

    logic [31:0]   link_word;
    logic [7:0]    pins_s;
    logic          strobe_s;
    logic          upd_s;
    logic          tgp_s;
    logic          clr_s;
    logic [2:0]    strap_s;
    logic          ot_s;
    logic          strobe_d;
    logic          upd_d;
    logic          tgp_d;
    logic [2:0]    init_pend;
    logic          upd_pend;
    logic [CW-1:0] code_a [8];
    logic [CW-1:0] code_b [8];
    logic [SW-1:0] span_in [8];
    logic [7:0]    tsel;

    logic          exec;
    logic [3:0]    cmd;
    logic [7:0]    addr_mask;
    logic [CW-1:0] new_code;
    logic [SW-1:0] new_span;
    logic          apply_def;
    logic [7:0]    wr_code;
    logic [7:0]    wr_span;
    logic [7:0]    upd_mask;
    logic [7:0]    pd_mask;
    logic [7:0]    tog_a;
    logic [7:0]    tog_b;
    logic          upd_fire;

    // Link domain; the word is read here only after the strobe rose
    link_shifter u_link (
        .i_sck      (i_sck),
        .i_strobe_n (i_select_load_strobe_n),
        .i_sdi      (i_sdi),
        .o_sdo      (o_sdo),
        .o_word     (link_word)
    );

    // Every control pin and the strobe cross on two flops before system-clock logic sees them
    level_sync #(
        .W       (8),
        .RST_VAL (8'hF6) // Idle levels; overtemp idles low
    ) u_sync (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_ce    (i_ce),
        .i_async ({i_select_load_strobe_n, i_async_update_n,
                   i_async_clear_n, i_span_strap_pins, i_toggle_pin,
                   i_overtemp}),
        .o_sync  (pins_s)
    );

    assign strobe_s = pins_s[7];
    assign upd_s    = pins_s[6];
    assign clr_s    = pins_s[5];
    assign strap_s  = pins_s[4:2];
    assign tgp_s    = pins_s[1];
    assign ot_s     = pins_s[0];

    // Frame fields; only the last 24 bits count, leading bits ignored
    assign exec     = strobe_s & ~strobe_d;
    assign cmd      = link_word[dac_ctrl_pkg::CMD_LSB +: 4];
    assign addr_mask = dac_ctrl_pkg::chan_mask(
        link_word[dac_ctrl_pkg::ADDR_LSB +: 4]);
    assign new_code = link_word[dac_ctrl_pkg::DATA_MSB -: CW];
    assign new_span = link_word[SW-1:0];
    assign apply_def = (|init_pend) | ~clr_s;

    // A deferred or immediate pin update of all channels
    assign upd_fire = (~upd_s & upd_d & strobe_s)
                    | (upd_pend & exec);

    // Command decode into channel masks
    always_comb begin
        wr_code  = 8'h00;
        wr_span  = 8'h00;
        upd_mask = upd_fire ? dac_ctrl_pkg::ALL_CH : 8'h00;
        pd_mask  = 8'h00;
        tog_a    = 8'h00;
        tog_b    = 8'h00;
        if (exec) begin
            unique case (cmd)
                dac_ctrl_pkg::CMD_WR_N: begin
                    wr_code = addr_mask;
                end
                dac_ctrl_pkg::CMD_WR_ALL: begin
                    wr_code = dac_ctrl_pkg::ALL_CH;
                end
                dac_ctrl_pkg::CMD_SPAN_N: begin
                    wr_span = addr_mask;
                end
                dac_ctrl_pkg::CMD_SPAN_ALL: begin
                    wr_span = dac_ctrl_pkg::ALL_CH;
                end
                dac_ctrl_pkg::CMD_UPD_N: begin
                    upd_mask = upd_mask | addr_mask;
                end
                dac_ctrl_pkg::CMD_UPD_ALL: begin
                    upd_mask = dac_ctrl_pkg::ALL_CH;
                end
                dac_ctrl_pkg::CMD_WR_UPD_N: begin
                    wr_code  = addr_mask;
                    upd_mask = upd_mask | addr_mask;
                end
                dac_ctrl_pkg::CMD_WR_N_UPD_A: begin
                    wr_code  = addr_mask;
                    upd_mask = dac_ctrl_pkg::ALL_CH;
                end
                dac_ctrl_pkg::CMD_WR_UPD_ALL: begin
                    wr_code  = dac_ctrl_pkg::ALL_CH;
                    upd_mask = dac_ctrl_pkg::ALL_CH;
                end
                dac_ctrl_pkg::CMD_PD_N: begin
                    pd_mask = addr_mask;
                end
                dac_ctrl_pkg::CMD_PD_CHIP: begin
                    pd_mask = dac_ctrl_pkg::ALL_CH;
                end
                dac_ctrl_pkg::CMD_GTOGGLE: begin
                    if (link_word[dac_ctrl_pkg::TG_BIT]) begin
                        tog_b = tsel;
                    end else begin
                        tog_a = tsel;
                    end
                end
                default: begin
                    // Mux, select, config and no-op act elsewhere
                end
            endcase
        end
        // Toggle pin edges, selected channels only
        if (~tgp_s & tgp_d) begin
            tog_a = tog_a | tsel;
        end
        if (tgp_s & ~tgp_d) begin
            tog_b = tog_b | tsel;
        end
        // Software power-down is ignored while the update pin is low
        if (!upd_s) begin
            pd_mask = 8'h00;
        end
    end

    // Edge history of the synchronised pins
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            strobe_d <= 1'b1;
            upd_d    <= 1'b1;
            tgp_d    <= 1'b1;
        end else if (i_ce) begin
            strobe_d <= strobe_s;
            upd_d    <= upd_s;
            tgp_d    <= tgp_s;
        end
    end

    // Strap defaults keep loading until the synchroniser has flushed
    // its reset value, so the third edge after release sees real straps
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            init_pend <= 3'h7;
        end else if (i_ce) begin
            init_pend <= {init_pend[1:0], 1'b0};
        end
    end

    // Deferred pin update; a new fall wins over the release
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            upd_pend <= 1'b0;
        end else if (i_ce) begin
            if (~upd_s & upd_d & ~strobe_s) begin
                upd_pend <= 1'b1;
            end else if (exec) begin
                upd_pend <= 1'b0;
            end
        end
    end

    // Input registers; a selected channel's code write goes to B
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            for (int i = 0; i < 8; i++) begin
                code_a[i]  <= dac_ctrl_pkg::ZERO_CODE;
                code_b[i]  <= dac_ctrl_pkg::ZERO_CODE;
                span_in[i] <= dac_ctrl_pkg::RST_SPAN;
            end
        end else if (i_ce) begin
            for (int i = 0; i < 8; i++) begin
                if (apply_def) begin
                    code_a[i]  <= dac_ctrl_pkg::strap_code(strap_s);
                    code_b[i]  <= dac_ctrl_pkg::strap_code(strap_s);
                    span_in[i] <= dac_ctrl_pkg::strap_span(strap_s);
                end else begin
                    if (wr_code[i] && tsel[i]) begin
                        code_b[i] <= new_code;
                    end else if (wr_code[i]) begin
                        code_a[i] <= new_code;
                    end
                    if (wr_span[i]) begin
                        span_in[i] <= new_span;
                    end
                end
            end
        end
    end

    // Converter registers; an update in the same frame as a write
    // takes the new value when the channel's toggle select bit is 0, so write-and-update acts as one step
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_dac_code <= '0;
            o_dac_span <= '0;
        end else if (i_ce) begin
            for (int i = 0; i < 8; i++) begin
                if (apply_def) begin
                    o_dac_code[i*CW +: CW] <=
                        dac_ctrl_pkg::strap_code(strap_s);
                    o_dac_span[i*SW +: SW] <=
                        dac_ctrl_pkg::strap_span(strap_s);
                end else if (tog_b[i]) begin
                    o_dac_code[i*CW +: CW] <= code_b[i];
                    o_dac_span[i*SW +: SW] <= span_in[i];
                end else if (tog_a[i] || upd_mask[i]) begin
                    o_dac_code[i*CW +: CW] <=
                        (wr_code[i] && !tsel[i]) ? new_code
                                                 : code_a[i];
                    o_dac_span[i*SW +: SW] <= span_in[i];
                end
            end
        end
    end

    // Channel power; updates and toggles power up, pin low holds up
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_dac_power <= dac_ctrl_pkg::ALL_CH;
        end else if (i_ce) begin
            if (!upd_s) begin
                o_dac_power <= dac_ctrl_pkg::ALL_CH;
            end else begin
                o_dac_power <= (o_dac_power & ~pd_mask)
                             | upd_mask | tog_a | tog_b;
            end
        end
    end

    // Reference off on chip power-down, on again at any update or update pin low, not on toggles; mux clears on chip power-down
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_ref_en          <= 1'b1;
            o_monitor_mux_sel <= '0;
        end else if (i_ce) begin
            if (!clr_s) begin
                o_monitor_mux_sel <= '0;
            end else if (exec && cmd == dac_ctrl_pkg::CMD_MUX) begin
                o_monitor_mux_sel <= link_word[4:0];
            end else if (exec && cmd == dac_ctrl_pkg::CMD_PD_CHIP
                         && upd_s) begin
                o_monitor_mux_sel <= '0;
            end
            if (exec && cmd == dac_ctrl_pkg::CMD_PD_CHIP && upd_s) begin
                o_ref_en <= 1'b0;
            end else if (|upd_mask || !upd_s) begin
                o_ref_en <= 1'b1;
            end
        end
    end

    // Toggle select and config registers; clear zeroes both
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            tsel     <= 8'h00;
            o_config <= '0;
        end else if (i_ce) begin
            if (!clr_s) begin
                tsel     <= 8'h00;
                o_config <= '0;
            end else if (exec && cmd == dac_ctrl_pkg::CMD_TSEL) begin
                tsel <= link_word[7:0];
            end else if (exec && cmd == dac_ctrl_pkg::CMD_CONFIG) begin
                o_config <= link_word[3:0];
            end
        end
    end

    // Serial output released while the strobe is high; lags the pin
    // by the synchroniser, a trade for keeping one clean domain
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_sdo_oe_n <= 1'b1;
        end else if (i_ce) begin
            o_sdo_oe_n <= strobe_s;
        end
    end

    // Open-drain flag; a new overtemperature wins over the release
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_overtemp_flag_n    <= 1'b0;
            o_overtemp_flag_oe_n <= 1'b1;
        end else if (i_ce) begin
            o_overtemp_flag_n <= 1'b0;
            if (ot_s) begin
                o_overtemp_flag_oe_n <= 1'b0;
            end else if (exec) begin
                o_overtemp_flag_oe_n <= 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// ---- test/host_model.sv ----
/*
 * Serial host model: drives frames of 24 or 32 bits on the link and
 * captures the echoed serial output just before each rising clock.
 * Assumes a pull-up on the serial output wire while it is released.
 */
`timescale 1ns/1ps
`default_nettype none

module host_model (
    // Echo path from the device
    input  wire logic        i_sdo,
    input  wire logic        i_sdo_oe_n,
    // Link drive
    output logic             o_sck,
    output logic             o_sdi,
    output logic             o_strobe_n,
    // Captured echo word
    output logic [31:0]      o_rx
);
    logic pin;

    // Released output floats up through the pull-up
    assign pin = i_sdo_oe_n ? 1'b1 : i_sdo;

    // Idle link: clock low, strobe high
    initial begin
        o_sck      = 1'b0;
        o_sdi      = 1'b0;
        o_strobe_n = 1'b1;
        o_rx       = 32'h0000_0000;
    end

    // One frame, MSB first; clock held idle outside the frame
    task automatic send(input logic [31:0] w, input int n);
        o_strobe_n = 1'b0;
        #90; // Let the synchronised output enable settle before capture
        for (int i = n - 1; i >= 0; i--) begin
            o_sdi = w[i];
            #15;
            o_rx  = {o_rx[30:0], pin};
            o_sck = 1'b1;
            #15;
            o_sck = 1'b0;
        end
        #15;
        o_strobe_n = 1'b1;
        o_sdi      = ~o_sdi; // Stale data is not held valid
        #300; // Strobe high well beyond four system clocks
    endtask
endmodule

`default_nettype wire

// ---- test/dac_ctrl_asserts.sv ----
/*
 * Port checker for the converter control block.
 * Assumes i_ce held high and strobe high for >= 4 clocks between frames.
 */
`timescale 1ns/1ps
`default_nettype none

module dac_ctrl_checker (
    // Clock and reset
    input wire logic         i_clk,
    input wire logic         i_rst_n,
    // Watched ports
    input wire logic         i_select_load_strobe_n,
    input wire logic         i_async_update_n,
    input wire logic         i_async_clear_n,
    input wire logic [2:0]   i_span_strap_pins,
    input wire logic         i_overtemp,
    input wire logic         o_sdo_oe_n,
    input wire logic         o_overtemp_flag_oe_n,
    input wire logic [127:0] o_dac_code,
    input wire logic [23:0]  o_dac_span,
    input wire logic [7:0]   o_dac_power,
    input wire logic         o_ref_en,
    input wire logic [4:0]   o_monitor_mux_sel,
    input wire logic [3:0]   o_config
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    a_sdo_released: assert property (i_select_load_strobe_n [*4] |-> o_sdo_oe_n)
        else $error("serial output driven while strobe high");
    a_sdo_driven: assert property (!i_select_load_strobe_n [*4] |-> !o_sdo_oe_n)
        else $error("serial output released inside a frame");
    a_flag_sets: assert property (i_overtemp |-> ##[1:5] !o_overtemp_flag_oe_n)
        else $error("overtemperature flag not pulled low");
    a_flag_holds: assert property ($rose(o_overtemp_flag_oe_n) |-> i_select_load_strobe_n)
        else $error("flag released without strobe rise");
    a_clear_ctrl: assert property (!i_async_clear_n [*4] |-> o_config == 4'h0 && o_monitor_mux_sel == 5'h00)
        else $error("control registers not zero under clear");
    a_clear_code: assert property ((!i_async_clear_n && i_span_strap_pins == 3'h0) [*4]
        |-> o_dac_code[15:0] == 16'h8000 && o_dac_span[2:0] == 3'h3)
        else $error("clear did not force strap code and span");
    a_update_power: assert property (!i_async_update_n [*4] |-> o_dac_power == 8'hFF)
        else $error("update pin low but channel powered down");
    a_code_quiet: assert property ($changed(o_dac_code) |-> i_select_load_strobe_n && $past(i_select_load_strobe_n, 2))
        else $error("converter code changed inside a frame");
    a_chip_down: assert property ($fell(o_ref_en) |-> o_dac_power == 8'h00)
        else $error("reference off with channels powered");
endmodule

bind dac_serial_ctrl dac_ctrl_checker chk_u (.*);

`default_nettype wire

// ---- test/tb_top.sv ----
/*
 * Self-checking bench: frames through the host model, pin events driven
 * here. Assumes straps at 000 (mid-scale code, span 011) except in the
 * clear test, which moves them to 011 and back.
 */
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end

module tb_top;
    logic i_clk, i_rst_n, upd_n, tgl, clr_n, ovt;
    logic sck, sdi, strb_n, sdo, sdo_oe_n, flag_n, flag_oe_n, ref_en;
    logic [127:0] code_o;
    logic [23:0]  span_o;
    logic [7:0]   power_o;
    logic [4:0]   mux_o;
    logic [3:0]   cfg_o;
    logic [31:0]  rx;
    logic [2:0]   strap;
    int failures = 0;
    int check_count = 0;

    host_model host_u (.i_sdo(sdo), .i_sdo_oe_n(sdo_oe_n), .o_sck(sck),
        .o_sdi(sdi), .o_strobe_n(strb_n), .o_rx(rx));

    dac_serial_ctrl dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(1'b1),
        .i_sck(sck), .i_sdi(sdi), .i_select_load_strobe_n(strb_n),
        .o_sdo(sdo), .o_sdo_oe_n(sdo_oe_n), .i_async_update_n(upd_n),
        .i_toggle_pin(tgl), .i_async_clear_n(clr_n),
        .i_span_strap_pins(strap), .i_overtemp(ovt),
        .o_overtemp_flag_n(flag_n), .o_overtemp_flag_oe_n(flag_oe_n),
        .o_dac_code(code_o), .o_dac_span(span_o), .o_dac_power(power_o),
        .o_ref_en(ref_en), .o_monitor_mux_sel(mux_o), .o_config(cfg_o));

    // Open-drain flag as seen through its pull-up
    function automatic logic flag_pin();
        return flag_oe_n ? 1'b1 : flag_n;
    endfunction

    function automatic logic [15:0] code(input int i);
        return code_o[16*i +: 16];
    endfunction

    task automatic w(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    task automatic frame(input logic [3:0] c, a, input logic [15:0] d);
        host_u.send({8'h00, c, a, d}, 24);
    endtask

    task automatic end_sim();
        if (failures == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // 40 MHz system clock
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end

    // Watchdog sized well above the roughly 31 us of traffic
    initial begin
        #200us;
        failures++;
        end_sim();
    end

    // Main sequence
    initial begin
        {i_rst_n, upd_n, tgl, clr_n, ovt} = 5'b01110;
        strap = 3'h0;
        w(20);
        i_rst_n <= 1'b1;
        w(5);
        `CHK(code(0), 16'h8000)
        `CHK(span_o[2:0], 3'h3)
        frame(4'h0, 4'h2, 16'h1234);
        `CHK(code(2), 16'h8000)
        frame(4'h1, 4'h2, 16'h0000);
        `CHK(code(2), 16'h1234)
        host_u.send(32'hC335_ABCD, 32);
        `CHK(code(5), 16'hABCD)
        host_u.send(32'h00F0_0000, 32);
        `CHK(rx, 32'hC335_ABCD)
        frame(4'hE, 4'h0, 16'h0002);
        frame(4'h9, 4'h0, 16'h0000);
        `CHK(span_o[23:21], 3'h2)
        frame(4'h4, 4'h1, 16'h0000);
        `CHK(power_o, 8'hFD)
        frame(4'h5, 4'h0, 16'h0000);
        `CHK({power_o, ref_en}, 9'h000)
        frame(4'h9, 4'h0, 16'h0000);
        `CHK({power_o, ref_en}, 9'h1FF)
        frame(4'h3, 4'h8, 16'hFFFF);
        `CHK(code(7), 16'h8000)
        frame(4'h0, 4'h0, 16'h1111);
        frame(4'hC, 4'h0, 16'h0001);
        frame(4'h0, 4'h0, 16'h2222);
        frame(4'h0, 4'h1, 16'h3333);
        tgl <= 1'b0;
        w(8);
        `CHK({code(0), code(1)}, 32'h1111_8000)
        tgl <= 1'b1;
        w(8);
        `CHK(code(0), 16'h2222)
        frame(4'hD, 4'h0, 16'h0000);
        `CHK(code(0), 16'h1111)
        frame(4'h0, 4'h3, 16'h4444);
        upd_n <= 1'b0;
        w(8);
        `CHK(code(3), 16'h4444)
        frame(4'h4, 4'h3, 16'h0000);
        `CHK(power_o, 8'hFF)
        upd_n <= 1'b1;
        frame(4'h0, 4'h4, 16'h5555);
        fork
            frame(4'hF, 4'h0, 16'h0000);
            begin
                w(10);
                upd_n <= 1'b0;
                w(8);
                `CHK(code(4), 16'h8000)
            end
        join
        `CHK(code(4), 16'h5555)
        upd_n <= 1'b1;
        frame(4'h8, 4'h0, 16'h6666);
        frame(4'h2, 4'h6, 16'h7777);
        `CHK({code(6), code(7)}, 32'h7777_6666)
        frame(4'hA, 4'h0, 16'h9999);
        `CHK(code(7), 16'h9999)
        frame(4'hB, 4'h0, 16'h0011);
        frame(4'h7, 4'h0, 16'h0005);
        `CHK({mux_o, cfg_o}, 9'h115)
        clr_n <= 1'b0;
        w(8);
        `CHK({mux_o, cfg_o, code(2)}, 25'h0008000)
        strap <= 3'h3;
        w(8);
        `CHK({code(2), span_o[2:0]}, 19'h00001)
        strap <= 3'h0;
        w(8);
        clr_n <= 1'b1;
        ovt <= 1'b1;
        w(5);
        ovt <= 1'b0;
        w(25);
        `CHK(flag_pin(), 1'b0)
        frame(4'hF, 4'h0, 16'h0000);
        `CHK(flag_pin(), 1'b1)
        end_sim();
    end
endmodule

`default_nettype wire
